// File: rtl/ecpfh_defines.svh
// Timing constants for the parallel port handshake engine
`ifndef ECPFH_DEFINES_SVH
`define ECPFH_DEFINES_SVH
`define ECPFH_CLK_NS        100
`define ECPFH_SETUP_NS      600
`define ECPFH_STROBE_NS     600
`define ECPFH_HOLD_NS       450
`define ECPFH_BUSY_GAP_NS   680
`define ECPFH_FILT_MIN_NS   75
`define ECPFH_RESP_MIN_NS   80
`define ECPFH_RESP_MAX_NS   200
// Least times round up, one cycle at the least
`define ECPFH_CYC_UP(ns)    ((((ns) + `ECPFH_CLK_NS - 1) / `ECPFH_CLK_NS) < 1 ? 1 : \
                             (((ns) + `ECPFH_CLK_NS - 1) / `ECPFH_CLK_NS))
`define ECPFH_SETUP_CYC     `ECPFH_CYC_UP(`ECPFH_SETUP_NS)
`define ECPFH_STROBE_CYC    `ECPFH_CYC_UP(`ECPFH_STROBE_NS)
`define ECPFH_HOLD_CYC      `ECPFH_CYC_UP(`ECPFH_HOLD_NS)
`define ECPFH_BUSY_GAP_CYC  `ECPFH_CYC_UP(`ECPFH_BUSY_GAP_NS)
`define ECPFH_FILT_CYC      `ECPFH_CYC_UP(`ECPFH_FILT_MIN_NS)
`define ECPFH_RESP_CYC      `ECPFH_CYC_UP(`ECPFH_RESP_MIN_NS)
`define ECPFH_CNT_W         4
`endif

// File: rtl/ecpfh_pkg.sv
// Types for the parallel port handshake engine
package ecpfh_pkg;
  // Operating mode of the port
  typedef enum logic [1:0] {
    ecpfh_mode_compat_fifo,
    ecpfh_mode_ecp_fwd,
    ecpfh_mode_ecp_rev
  } ecpfh_mode_t;
  // Cable pins driven by the host
  typedef struct packed {
    logic [7:0] data;       // cable_data_bus level
    logic       data_oe;    // Data drivers on
    logic       strobe;     // host_strobe_line / HostClk level
    logic       strobe_oe;  // Strobe driver on
    logic       autofeed;   // autofeed_line / HostAck level
    logic       autofeed_oe;// Autofeed driver on
    logic       push_pull;  // Totem-pole drivers selected
  } ecpfh_pins_t;
endpackage

// File: rtl/ecpfh_engine.sv
// Parallel port FIFO and extended-capability handshake engine
//   Contract
// - Compat FIFO: next byte on busy only
// - Forward idle: HostClk high, ack low
// - Forward: wait ack low, strobe, release
// - Reverse request accepted at any time; code reports it in extended forward mode only
// - Reverse idle: PeriphClk high, HostAck low
// - Reverse: HostAck up, latch, HostAck down
// - Driver type switches without output glitch
// - Data setup and strobe width 600 ns
// - Data hold 450 ns or busy
// - Strobe waits 680 ns after busy
// - PeriphAck filtered 75 to 130 ns
// - PeriphClk filtered 75 to 130 ns
// - HostClk 80 to 200 ns after ack
// - HostAck 80 to 200 ns after PeriphClk
// - Stall HostAck on full or count
`timescale 1ns/10ps
`include "ecpfh_defines.svh"
module ecpfh_engine (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  clk_en,
  input  wire ecpfh_pkg::ecpfh_mode_t mode,
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  input  wire logic [7:0]            tx_data,
  output logic                       rx_valid,
  output logic [7:0]                 rx_data,
  input  wire logic                  rx_room,
  input  wire logic                  term_count,
  input  wire logic                  busy_pin,
  input  wire logic                  ack_pin,
  input  wire logic                  fault_line_n,
  input  wire logic [7:0]            data_pin,
  output ecpfh_pkg::ecpfh_pins_t     pins,
  output logic                       rev_request
);
  localparam int CW = `ECPFH_CNT_W;
  localparam logic [CW-1:0] SETUP_C = CW'(`ECPFH_SETUP_CYC);
  localparam logic [CW-1:0] STROBE_C = CW'(`ECPFH_STROBE_CYC);
  localparam logic [CW-1:0] HOLD_C = CW'(`ECPFH_HOLD_CYC);
  localparam logic [CW-1:0] GAP_C = CW'(`ECPFH_BUSY_GAP_CYC);
  localparam logic [CW-1:0] FILT_C = CW'(`ECPFH_FILT_CYC);
  localparam logic [CW-1:0] RESP_C = CW'(`ECPFH_RESP_CYC);

  // Saturating count-down step
  function automatic logic [CW-1:0] dec_sat(input logic [CW-1:0] v);
    dec_sat = (v == '0) ? '0 : v - CW'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] sync1_r;   // First stage, read only by second
  logic [2:0] sync2_r;   // Second stage, safe to use
  logic [7:0] dsync1_r;  // Data first stage
  logic [7:0] dsync2_r;  // Data second stage
  // Two flops per cable input before any use
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // Idle levels: request high, PeriphClk high, busy low; avoids a false busy edge
      sync1_r  <= 3'h6;
      sync2_r  <= 3'h6;
      dsync1_r <= 8'h00;
      dsync2_r <= 8'h00;
    end else if (clk_en) begin
      sync1_r  <= {fault_line_n, ack_pin, busy_pin};
      sync2_r  <= sync1_r;
      dsync1_r <= data_pin;
      dsync2_r <= dsync1_r;
    end
  end
  wire busy_s = sync2_r[0];  // PeriphAck / Busy
  wire ack_s  = sync2_r[1];  // PeriphClk / periph_ack_pulse_line
  wire req_s  = ~sync2_r[2]; // Reverse request, active when low

  ////////////////////////////////////////////////////////////////////
  // Glitch filters: level accepted once stable for the interval
  logic          busy_f_r;    // Filtered busy
  logic          ack_f_r;     // Filtered PeriphClk
  logic [CW-1:0] bfc_r;       // Busy stability count
  logic [CW-1:0] afc_r;       // PeriphClk stability count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_f_r <= 1'b0;
      bfc_r    <= '0;
    end else if (clk_en) begin
      if (busy_s == busy_f_r) begin
        bfc_r <= '0;
      end else if (bfc_r >= FILT_C - CW'(1)) begin
        busy_f_r <= busy_s;
        bfc_r    <= '0;
      end else begin
        bfc_r <= bfc_r + CW'(1);
      end
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_f_r <= 1'b1;
      afc_r   <= '0;
    end else if (clk_en) begin
      if (ack_s == ack_f_r) begin
        afc_r <= '0;
      end else if (afc_r >= FILT_C - CW'(1)) begin
        ack_f_r <= ack_s;
        afc_r   <= '0;
      end else begin
        afc_r <= afc_r + CW'(1);
      end
    end
  end

  // Request is level-sensitive and honoured in any forward state, in extended forward mode only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rev_request <= 1'b0;
    end else if (clk_en) begin
      rev_request <= req_s && (mode == ecpfh_pkg::ecpfh_mode_ecp_fwd);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Forward engine (compat FIFO and extended forward)
  typedef enum logic [2:0] {
    F_IDLE, F_SETUP, F_STROBE, F_WAIT_BUSY, F_HOLD, F_GAP
  } ecpfh_fst_t;
  ecpfh_fst_t    fst_r;     // Forward state
  logic [CW-1:0] ftm_r;     // Forward timer
  logic [7:0]    fdata_r;   // Byte on the cable
  logic          strobe_r;  // HostClk level, high idle
  wire compat = (mode == ecpfh_pkg::ecpfh_mode_compat_fifo);
  wire fwd_on = compat || (mode == ecpfh_pkg::ecpfh_mode_ecp_fwd);
  assign tx_ready = fwd_on && (fst_r == F_IDLE) && !busy_f_r;
  // Ack pulse line deliberately not consulted in compat mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fst_r    <= F_IDLE;
      ftm_r    <= '0;
      fdata_r  <= 8'h00;
      strobe_r <= 1'b1;
    end else if (clk_en) begin
      ftm_r <= dec_sat(ftm_r);
      case (fst_r)
        F_IDLE: begin
          strobe_r <= 1'b1;
          if (tx_valid && tx_ready) begin
            fdata_r <= tx_data;
            if (compat) begin
              ftm_r <= SETUP_C;
              fst_r <= F_SETUP;
            end else begin
              // Extended: data and HostClk together; a setup stage here
              // would push HostClk past 200 ns after filtered PeriphAck
              strobe_r <= 1'b0;
              ftm_r    <= '0;
              fst_r    <= F_STROBE;
            end
          end
        end
        F_SETUP: begin
          if (ftm_r <= CW'(1)) begin
            strobe_r <= 1'b0;
            ftm_r    <= compat ? STROBE_C : '0;
            fst_r    <= F_STROBE;
          end
        end
        F_STROBE: begin
          if (compat) begin
            if (ftm_r <= CW'(1)) begin
              strobe_r <= 1'b1;
              ftm_r    <= HOLD_C;
              fst_r    <= F_HOLD;
            end
          end else if (busy_f_r) begin
            strobe_r <= 1'b1;
            fst_r    <= F_WAIT_BUSY;
          end
        end
        F_WAIT_BUSY: begin
          // Peripheral lowers PeriphAck when ready for the next byte
          if (!busy_f_r) begin
            fst_r <= F_IDLE;
          end
        end
        F_HOLD: begin
          if (ftm_r <= CW'(1) && !busy_f_r) begin
            ftm_r <= GAP_C;
            fst_r <= F_GAP;
          end
        end
        F_GAP: begin
          if (busy_f_r) begin
            ftm_r <= GAP_C;
          end else if (ftm_r <= CW'(1)) begin
            fst_r <= F_IDLE;
          end
        end
        default: fst_r <= F_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reverse engine
  typedef enum logic [1:0] {R_IDLE, R_RESP, R_ACKED} ecpfh_rst_t;
  ecpfh_rst_t    rst_r;     // Reverse state
  logic [CW-1:0] rtm_r;     // Reverse timer
  logic          hack_r;    // HostAck level
  wire rev_on  = (mode == ecpfh_pkg::ecpfh_mode_ecp_rev);
  wire can_rx  = rx_room && !term_count;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_r    <= R_IDLE;
      rtm_r    <= '0;
      hack_r   <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else if (clk_en) begin
      rx_valid <= 1'b0;
      rtm_r    <= dec_sat(rtm_r);
      case (rst_r)
        R_IDLE: begin
          hack_r <= 1'b0;
          if (rev_on && !ack_f_r) begin
            rtm_r <= RESP_C;
            rst_r <= R_RESP;
          end
        end
        R_RESP: begin
          // Held low while stalled
          if (!rev_on) begin
            rst_r <= R_IDLE;
          end else if (rtm_r <= CW'(1) && can_rx) begin
            hack_r <= 1'b1;
            rst_r  <= R_ACKED;
          end
        end
        R_ACKED: begin
          if (ack_f_r) begin
            rx_data  <= dsync2_r;
            rx_valid <= 1'b1;
            hack_r   <= 1'b0;
            rst_r    <= R_IDLE;
          end
        end
        default: rst_r <= R_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin drive; driver type changes only while forward is idle
  logic pp_r;  // Push-pull selected
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pp_r <= 1'b0;
    end else if (clk_en && fst_r == F_IDLE && strobe_r) begin
      pp_r <= !compat;
    end
  end
  // Open collector strobe and autofeed only drive lows; push-pull drives both levels; data drives both levels outside reverse
  always_comb begin
    pins.data        = fdata_r;
    pins.data_oe     = !rev_on;
    pins.strobe      = strobe_r;
    pins.strobe_oe   = pp_r || !strobe_r;
    pins.autofeed    = hack_r;
    pins.autofeed_oe = pp_r || !hack_r;
    pins.push_pull   = pp_r;
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_strobe_width: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && compat && $fell(strobe_r)) |-> !strobe_r [*6])
    else $error("strobe pulse too short");
  a_idle_strobe: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fst_r == F_IDLE && $past(fst_r) == F_IDLE) |-> strobe_r)
    else $error("HostClk low while idle");
  a_fwd_release: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !compat && fst_r == F_STROBE && busy_f_r) |=> strobe_r)
    else $error("HostClk not released after ack");
  a_fwd_resp: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !compat && fst_r == F_IDLE && tx_valid && tx_ready) |=> !strobe_r)
    else $error("HostClk late after take");
  a_stall_hack: assert property (@(posedge ref_clk) disable iff (!resetn)
    (rst_r == R_RESP && !can_rx) |=> !hack_r)
    else $error("HostAck raised while stalled");
  a_rev_resp: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && rev_on && rst_r == R_IDLE && !ack_f_r) ##1 (clk_en && rev_on && can_rx)
    |=> hack_r)
    else $error("HostAck late after PeriphClk");
  a_rev_latch: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && rst_r == R_ACKED && ack_f_r) |=> (rx_valid && !hack_r))
    else $error("reverse byte not latched");
  a_busy_filter: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && $changed(busy_f_r)) |-> $past(busy_s) == busy_f_r)
    else $error("busy filter took unstable level");
  a_ack_filter: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && $changed(ack_f_r)) |-> $past(ack_s) == ack_f_r)
    else $error("PeriphClk filter took unstable level");
  a_gap_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && fst_r == F_GAP && busy_f_r) |=> fst_r == F_GAP)
    else $error("strobe gap ended while busy");
  a_hold_data: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fst_r != F_IDLE && $past(fst_r) != F_IDLE) |-> $stable(fdata_r))
    else $error("data changed during transfer");
  a_pp_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(pp_r) |-> $past(strobe_r))
    else $error("driver type changed mid pulse");
  c_compat_byte: cover property (@(posedge ref_clk) compat && fst_r == F_GAP);
  c_fwd_byte: cover property (@(posedge ref_clk) !compat && fst_r == F_WAIT_BUSY);
  c_rev_byte: cover property (@(posedge ref_clk) rx_valid);
  c_rev_stall: cover property (@(posedge ref_clk) rst_r == R_RESP && term_count);
endmodule

// File: testbench/ecpfh_periph_model.sv
// Peripheral on the far end of the parallel cable
`timescale 1ns/10ps
module ecpfh_periph_model (
  input  wire logic                  ref_clk,
  input  wire ecpfh_pkg::ecpfh_mode_t mode,
  input  wire logic                  slow,
  input  wire ecpfh_pkg::ecpfh_pins_t pins,
  output logic                       busy_pin,
  output logic                       ack_pin,
  output logic [7:0]                 data_pin
);
  logic [7:0] got_q[$]; // Bytes taken off the cable
  int         n;        // Bound on each pin polling loop; the wait for a strobe fall has no bound
  initial begin
    busy_pin = 1'b0;
    ack_pin  = 1'b1;
    data_pin = 8'h5a;
  end
  // Forward: ack after strobe falls, release after it rises
  always begin
    @(negedge pins.strobe);
    if (mode != ecpfh_pkg::ecpfh_mode_ecp_rev) begin
      got_q.push_back(pins.data);
      repeat (slow ? 4 : 1) @(negedge ref_clk);
      busy_pin = 1'b1;
      n = 0;
      while (pins.strobe !== 1'b1 && n < 100) begin
        @(negedge ref_clk);
        n++;
      end
      repeat (slow ? 5 : 1) @(negedge ref_clk);
      busy_pin = 1'b0;
      // Printer still pulses its ack line; must not pace the host
      if (mode == ecpfh_pkg::ecpfh_mode_compat_fifo) begin
        ack_pin = 1'b0;
        @(negedge ref_clk);
        ack_pin = 1'b1;
      end
    end
  end
  // Reverse: one byte, held through the whole handshake
  task automatic send(input logic [7:0] b);
    @(negedge ref_clk);
    data_pin = b;
    repeat (2) @(negedge ref_clk);
    ack_pin = 1'b0;
    n = 0;
    while (pins.autofeed !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (slow ? 3 : 1) @(negedge ref_clk);
    ack_pin = 1'b1;
    n = 0;
    while (pins.autofeed !== 1'b0 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    // Released data no longer shows the byte
    data_pin = ~b;
  endtask
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the handshake engine
`timescale 1ns/10ps
module testbench;
  logic                   ref_clk = 1'b0;
  logic                   resetn = 1'b0;
  ecpfh_pkg::ecpfh_mode_t mode = ecpfh_pkg::ecpfh_mode_compat_fifo;
  logic                   tx_valid = 1'b0, tx_ready, rx_valid, rx_room = 1'b1;
  logic                   term_count = 1'b0, fault_line_n = 1'b1, rev_request, slow = 1'b1;
  logic [7:0]             tx_data = 8'h00, rx_data, data_pin;
  logic                   busy_pin, ack_pin;
  ecpfh_pkg::ecpfh_pins_t pins;
  logic [31:0]            seed = 32'h6fe12ea3;
  logic [7:0]             exp_tx[$], exp_rx[$];
  int                     mismatches = 0, checks = 0, cyc = 0, n;
  realtime                t_data = 0, t_fall = 0, t_rise = 0, t_busy = -1, t_ack = 0;
  always #50 ref_clk = ~ref_clk;
  ecpfh_engine ecpfh_engine_i (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1), .mode(mode),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_room(rx_room), .term_count(term_count), .busy_pin(busy_pin),
    .ack_pin(ack_pin), .fault_line_n(fault_line_n), .data_pin(data_pin), .pins(pins),
    .rev_request(rev_request));
  ecpfh_periph_model ecpfh_periph_model_i (.ref_clk(ref_clk), .mode(mode), .slow(slow),
    .pins(pins), .busy_pin(busy_pin), .ack_pin(ack_pin), .data_pin(data_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // Random source
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Compare helpers, one per result kind
  task automatic chk_byte(input logic [7:0] a, input logic [7:0] e);
    checks++;
    if (a !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic chk_bit(input logic a, input logic e);
    chk_byte({7'h00, a}, {7'h00, e});
  endtask
  task automatic chk_time(input realtime a, input realtime lo);
    checks++;
    if (a < lo) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, int'(a), int'(lo));
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Offer one byte; held until the edge that sees tx_ready
  task automatic send_tx(input logic [7:0] b);
    @(negedge ref_clk);
    tx_valid = 1'b1;
    tx_data  = b;
    n = 0;
    while (tx_ready !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk_bit(tx_ready, 1'b1);
    exp_tx.push_back(b);
    @(negedge ref_clk);
    tx_valid = 1'b0;
  endtask
  // Cable timing monitors
  always @(pins.data) begin
    if (resetn && mode == ecpfh_pkg::ecpfh_mode_compat_fifo && t_rise > 0) begin
      chk_time($realtime - t_rise, 450);
      chk_bit(busy_pin, 1'b0);
      t_rise = 0;
    end
    t_data = $realtime;
  end
  always @(negedge pins.strobe) begin
    t_fall = $realtime;
    if (resetn && mode == ecpfh_pkg::ecpfh_mode_compat_fifo) begin
      chk_time($realtime - t_data, 600);
      if (t_busy >= 0) chk_time($realtime - t_busy, 680);
    end
    if (resetn && mode == ecpfh_pkg::ecpfh_mode_ecp_fwd && t_busy >= 0)
      chk_time($realtime - t_busy, 80);
  end
  always @(posedge pins.strobe) begin
    if (resetn && mode == ecpfh_pkg::ecpfh_mode_compat_fifo) begin
      chk_time($realtime - t_fall, 600);
      t_rise = $realtime;
    end
  end
  always @(negedge busy_pin) t_busy = $realtime;
  // HostAck must not answer a PeriphClk fall sooner than 80 ns
  always @(negedge ack_pin) t_ack = $realtime;
  always @(posedge pins.autofeed) begin
    if (resetn && mode == ecpfh_pkg::ecpfh_mode_ecp_rev)
      chk_time($realtime - t_ack, 80);
  end
  // Received bytes against the model queue
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) chk_byte(rx_data, exp_rx.size() ? exp_rx.pop_front() : 8'hxx);
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // Compare bytes the peripheral took with those offered
  task automatic chk_fwd();
    repeat (40) @(negedge ref_clk);
    chk_byte(8'(ecpfh_periph_model_i.got_q.size()), 8'(exp_tx.size()));
    foreach (exp_tx[i]) chk_byte(ecpfh_periph_model_i.got_q[i], exp_tx[i]);
    ecpfh_periph_model_i.got_q.delete();
    exp_tx.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    chk_bit(pins.strobe, 1'b1);
    chk_bit(pins.push_pull, 1'b0);
    // Compatible FIFO mode, back-to-back bytes, slow and fast printer
    for (int i = 0; i < 4; i++) begin
      slow = i[0];
      send_tx(xs());
    end
    chk_fwd();
    // Extended forward phase
    mode = ecpfh_pkg::ecpfh_mode_ecp_fwd;
    t_busy = -1;
    repeat (10) @(negedge ref_clk);
    chk_bit(pins.push_pull, 1'b1);
    chk_bit(pins.strobe, 1'b1);
    for (int i = 0; i < 4; i++) begin
      slow = i[1];
      send_tx(xs());
    end
    chk_fwd();
    fault_line_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk_bit(rev_request, 1'b1);
    fault_line_n = 1'b1;
    // Reverse phase with stalls on full FIFO and terminal count
    mode = ecpfh_pkg::ecpfh_mode_ecp_rev;
    repeat (10) @(negedge ref_clk);
    chk_bit(pins.autofeed, 1'b0);
    for (int i = 0; i < 4; i++) begin
      exp_rx.push_back(xs());
      rx_room = (i != 1);
      term_count = (i == 2);
      fork
        ecpfh_periph_model_i.send(exp_rx[$]);
      join_none
      if (i == 1 || i == 2) begin
        repeat (20) @(negedge ref_clk);
        chk_bit(pins.autofeed, 1'b0);
        rx_room = 1'b1;
        term_count = 1'b0;
      end
      wait fork;
      repeat (4) @(negedge ref_clk);
    end
    chk_byte(8'(exp_rx.size()), 8'h00);
    end_sim();
  end
endmodule
